// File: logic/nvw_ctrl.sv
// Nonvolatile write controller: unlock, write latch, stall, block program, protect
//
// The register offsets and the strobed register port are this design's own decisions.
module nvw_ctrl
    import nvw_pkg::*;
#(
    parameter int PWRUP_CNT = PWRUP_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int EE_WRITE_CNT = EE_WRITE_CYCLES,
    parameter int EE_DEPTH = 256,
    parameter int PM_DEPTH = 8192
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic instr_slot,
    output logic instr_ignore,
    output logic cpu_halt,
    output logic irq,
    input wire logic data_protect_fuse,
    input wire logic ext_read,
    input wire logic [7:0] ext_addr,
    output logic [7:0] ext_rdata
);
    logic [7:0] ee_mem [EE_DEPTH];
    logic [13:0] pm_mem [PM_DEPTH];
    logic [13:0] pm_buf [8];
    logic program_memory_select, write_enable_latch, write_abort_flag, wr_bit;
    logic [7:0] nv_address_low, nv_address_high, nv_data_low, nv_data_high;
    logic [7:0] peripheral_irq_enable_2, peripheral_irq_flags_2;
    nvw_unlock_t unlock;
    nvw_state_t state;
    logic [WAIT_W-1:0] pwrup_cnt, busy_cnt;
    logic [1:0] slot_cnt;
    logic pwrup_done;

    wire [12:0] full_addr = {nv_address_high[4:0], nv_address_low};
    wire sel_ctl = reg_write && reg_addr == OFS_CONTROL;
    wire sel_unl = reg_write && reg_addr == OFS_UNLOCK;
    wire wr_req = sel_ctl && reg_wdata[CTL_WR] && !wr_bit;
    wire rd_req = sel_ctl && reg_wdata[CTL_RD] && state == NVW_IDLE;
    wire pgd_now = reg_wdata[CTL_PGD];
    wire wr_go = wr_req && unlock == NVW_ARMED && reg_wdata[CTL_WRITE_ENABLE_LATCH] && write_enable_latch
        && state == NVW_IDLE;
    wire ee_ok = wr_go && !pgd_now && pwrup_done;
    wire pm_go = wr_go && pgd_now;
    wire pm_last = nv_address_low[2:0] == BLOCK_LAST;
    wire done_evt = (state == NVW_EE_BUSY || state == NVW_PM_BUSY) && busy_cnt == '0;
    wire [7:0] irq_clear = (reg_write && reg_addr == OFS_IRQ_CLEAR) ? reg_wdata : 8'h00;
    wire [7:0] ctl_view = {program_memory_select, 3'b000, write_abort_flag,
        write_enable_latch, wr_bit, 1'b0};
    wire [12:0] blk_base = {full_addr[12:4], 4'h0};

    function automatic logic [7:0] rd_mux(input logic [3:0] a);
        unique case (a)
            OFS_CONTROL: rd_mux = ctl_view;
            OFS_ADDR_LO: rd_mux = nv_address_low;
            OFS_ADDR_HI: rd_mux = nv_address_high;
            OFS_DATA_LO: rd_mux = nv_data_low;
            OFS_DATA_HI: rd_mux = nv_data_high;
            OFS_IRQ_EN: rd_mux = peripheral_irq_enable_2;
            OFS_IRQ_FLAGS: rd_mux = peripheral_irq_flags_2;
            OFS_STATUS: rd_mux = {5'h00, state};
            default: rd_mux = RESET_BYTE;
        endcase
    endfunction : rd_mux

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrup_cnt <= '0;
            pwrup_done <= 1'b0;
        end else if (!pwrup_done) begin
            pwrup_cnt <= pwrup_cnt + 1'b1;
            pwrup_done <= pwrup_cnt == WAIT_W'(PWRUP_CNT - 1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            unlock <= NVW_LOCKED;
        end else if (sel_unl) begin
            unique case (unlock)
                NVW_LOCKED: unlock <= reg_wdata == UNLOCK_FIRST ? NVW_GOT55 : NVW_LOCKED;
                NVW_GOT55: unlock <= reg_wdata == UNLOCK_SECOND ? NVW_ARMED : NVW_LOCKED;
                NVW_ARMED: unlock <= reg_wdata == UNLOCK_FIRST ? NVW_GOT55 : NVW_LOCKED;
            endcase
        end else if (reg_write) begin
            // One arming per start attempt
            unlock <= NVW_LOCKED;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_memory_select <= 1'b0;
            write_enable_latch <= 1'b0;
            write_abort_flag <= 1'b0;
        end else if (sel_ctl) begin
            program_memory_select <= pgd_now;
            write_enable_latch <= reg_wdata[CTL_WRITE_ENABLE_LATCH];
            write_abort_flag <= reg_wdata[CTL_WRITE_ABORT_FLAG];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= NVW_IDLE;
            wr_bit <= 1'b0;
            busy_cnt <= '0;
            slot_cnt <= '0;
            cpu_halt <= 1'b0;
            instr_ignore <= 1'b0;
        end else begin
            unique case (state)
                NVW_IDLE: begin
                    instr_ignore <= 1'b0;
                    if (ee_ok) begin
                        state <= NVW_EE_BUSY;
                        wr_bit <= 1'b1;
                        busy_cnt <= WAIT_W'(EE_WRITE_CNT - 1);
                    end else if (pm_go) begin
                        state <= NVW_PM_SETUP;
                        slot_cnt <= 2'(SKIP_INSTR);
                        instr_ignore <= 1'b1;
                    end else if (rd_req && pgd_now) begin
                        state <= NVW_RD_WAIT;
                        slot_cnt <= 2'(SKIP_INSTR);
                    end
                end
                NVW_PM_SETUP: begin
                    if (instr_slot) begin
                        slot_cnt <= slot_cnt - 1'b1;
                    end
                    if (instr_slot && slot_cnt == 2'd1) begin
                        instr_ignore <= 1'b0;
                        state <= pm_last ? NVW_PM_BUSY : NVW_BUFFER;
                        cpu_halt <= pm_last;
                        wr_bit <= pm_last;
                        busy_cnt <= WAIT_W'(ERASE_CNT - 1);
                    end
                end
                NVW_BUFFER: state <= NVW_IDLE;
                NVW_RD_WAIT: begin
                    if (instr_slot) begin
                        slot_cnt <= slot_cnt - 1'b1;
                    end
                    instr_ignore <= instr_slot && slot_cnt == 2'd2;
                    if (instr_slot && slot_cnt == 2'd1) begin
                        state <= NVW_IDLE;
                    end
                end
                default: begin
                    busy_cnt <= busy_cnt - 1'b1;
                    if (done_evt) begin
                        wr_bit <= 1'b0;
                        cpu_halt <= 1'b0;
                        state <= NVW_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_address_low <= RESET_BYTE;
            nv_address_high <= RESET_BYTE;
            nv_data_low <= RESET_BYTE;
            nv_data_high <= RESET_BYTE;
            peripheral_irq_enable_2 <= RESET_BYTE;
        end else begin
            if (reg_write && reg_addr == OFS_ADDR_LO) nv_address_low <= reg_wdata;
            if (reg_write && reg_addr == OFS_ADDR_HI) nv_address_high <= reg_wdata & ADDR_HI_MASK;
            if (reg_write && reg_addr == OFS_IRQ_EN) peripheral_irq_enable_2 <= reg_wdata;
            if (rd_req && !pgd_now) begin
                nv_data_low <= ee_mem[nv_address_low];
            end else if (state == NVW_RD_WAIT && instr_slot && slot_cnt == 2'd1) begin
                nv_data_low <= pm_mem[full_addr][7:0];
                nv_data_high <= {2'b00, pm_mem[full_addr][13:8]};
            end else begin
                if (reg_write && reg_addr == OFS_DATA_LO) nv_data_low <= reg_wdata;
                if (reg_write && reg_addr == OFS_DATA_HI) nv_data_high <= reg_wdata & DATA_HI_MASK;
            end
        end
    end

    // Arrays carry no reset, large memories stay RAM-inferable
    always_ff @(posedge ref_clk) begin
        if (ee_ok) begin
            ee_mem[nv_address_low] <= nv_data_low;
        end
        if (pm_go) begin
            pm_buf[nv_address_low[2:0]] <= {nv_data_high[5:0], nv_data_low};
        end
        if (state == NVW_PM_BUSY && done_evt) begin
            for (int i = 0; i < 16; i++) begin
                pm_mem[blk_base | 13'(i)] <= (13'(i) >> 3) == 13'(full_addr[3])
                    ? pm_buf[i[2:0]] : 14'h3FFF;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            peripheral_irq_flags_2 <= RESET_BYTE;
            irq <= 1'b0;
            reg_rdata <= RESET_BYTE;
            ext_rdata <= RESET_BYTE;
        end else begin
            peripheral_irq_flags_2 <= (peripheral_irq_flags_2 & ~irq_clear)
                | (8'(done_evt) << IRQ_WRITE_DONE);
            irq <= |(peripheral_irq_flags_2 & peripheral_irq_enable_2);
            reg_rdata <= reg_read ? rd_mux(reg_addr) : RESET_BYTE;
            // external readout denied when fuse is zero
            if (ext_read) begin
                ext_rdata <= data_protect_fuse ? ee_mem[ext_addr] : RESET_BYTE;
            end
        end
    end
endmodule : nvw_ctrl

// File: logic/nvw_pkg.sv
// Package for the nonvolatile write controller: offsets, fields, timing
package nvw_pkg;
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_UNLOCK = 4'h1;
    localparam logic [3:0] OFS_ADDR_LO = 4'h2;
    localparam logic [3:0] OFS_ADDR_HI = 4'h3;
    localparam logic [3:0] OFS_DATA_LO = 4'h4;
    localparam logic [3:0] OFS_DATA_HI = 4'h5;
    localparam logic [3:0] OFS_IRQ_EN = 4'h6;
    localparam logic [3:0] OFS_IRQ_FLAGS = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'h9;
    // Control register fields
    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_WRITE_ENABLE_LATCH = 2;
    localparam int CTL_WRITE_ABORT_FLAG = 3;
    localparam int CTL_PGD = 7;
    // Interrupt flag/enable position of the write-done event
    localparam int IRQ_WRITE_DONE = 4;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [2:0] BLOCK_LAST = 3'h7;
    localparam logic [7:0] ADDR_HI_MASK = 8'h1F;
    localparam logic [7:0] DATA_HI_MASK = 8'h3F;
    localparam logic [7:0] CONTROL_MASK = 8'h8F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int PWRUP_MS = 64;
    localparam int PWRUP_CYCLES = PWRUP_MS * 1000 * CLK_MHZ;
    localparam int ERASE_US = 4000;
    localparam int ERASE_CYCLES = ERASE_US * CLK_MHZ;
    localparam int EE_WRITE_US = 4000;
    localparam int EE_WRITE_CYCLES = EE_WRITE_US * CLK_MHZ;
    localparam int SKIP_INSTR = 2;
    localparam int WAIT_W = 24;
    typedef enum logic [1:0] {NVW_LOCKED, NVW_GOT55, NVW_ARMED} nvw_unlock_t;
    typedef enum logic [2:0] {NVW_IDLE, NVW_BUFFER, NVW_EE_BUSY, NVW_PM_SETUP,
        NVW_PM_BUSY, NVW_RD_WAIT} nvw_state_t;
endpackage : nvw_pkg

// File: test/nvw_ctrl_monitor.sv
// Port checker for the nonvolatile write controller
module nvw_ctrl_monitor
    import nvw_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic instr_slot,
    input wire logic instr_ignore,
    input wire logic cpu_halt,
    input wire logic irq,
    input wire logic data_protect_fuse,
    input wire logic ext_read,
    input wire logic [7:0] ext_addr,
    input wire logic [7:0] ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic write_enable_latch_q;
    logic en_q;
    logic [7:0] addr_lo_q;
    // Wide enough for the full erase time at the default count
    logic [31:0] halt_cnt;
    wire ctl_w = reg_write && reg_addr == OFS_CONTROL;
    wire w55 = reg_write && reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_FIRST;
    wire waa = reg_write && reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_SECOND;
    wire pm_wr = ctl_w && reg_wdata[CTL_WR] && reg_wdata[CTL_PGD] && !reg_wdata[CTL_RD];
    wire pm_rd = ctl_w && reg_wdata[CTL_RD] && reg_wdata[CTL_PGD];
    // Shadows of software state, so antecedents know what was armed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_enable_latch_q <= 1'b0;
            en_q <= 1'b0;
            addr_lo_q <= 8'h00;
            halt_cnt <= 32'h00000000;
        end else begin
            write_enable_latch_q <= ctl_w ? reg_wdata[CTL_WRITE_ENABLE_LATCH] : write_enable_latch_q;
            en_q <= (reg_write && reg_addr == OFS_IRQ_EN) ? reg_wdata[IRQ_WRITE_DONE] : en_q;
            addr_lo_q <= (reg_write && reg_addr == OFS_ADDR_LO) ? reg_wdata : addr_lo_q;
            halt_cnt <= cpu_halt ? halt_cnt + 32'h00000001 : 32'h00000000;
        end
    end
    sequence s_unlock;
        w55 ##1 waa;
    endsequence
    sequence s_pm_start;
        s_unlock ##1 (pm_wr && reg_wdata[CTL_WRITE_ENABLE_LATCH] && write_enable_latch_q);
    endsequence
    property p_pm_start;
        s_pm_start |=> instr_ignore;
    endproperty
    a_pm_start: assert property (p_pm_start) else $error("program start skipped no slot");
    property p_no_start;
        pm_wr && !instr_ignore && !($past(waa) && write_enable_latch_q) |=> !instr_ignore;
    endproperty
    a_no_start: assert property (p_no_start) else $error("write started unarmed");
    property p_halt_soon;
        s_pm_start ##0 (addr_lo_q[2:0] == BLOCK_LAST) |-> ##[1:8] cpu_halt;
    endproperty
    a_halt_soon: assert property (p_halt_soon) else $error("last word did not halt core");
    property p_halt_len;
        $fell(cpu_halt) |-> int'(halt_cnt) == ERASE_CNT;
    endproperty
    a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
    property p_halt_write_enable_latch;
        $rose(cpu_halt) |-> write_enable_latch_q;
    endproperty
    a_halt_write_enable_latch: assert property (p_halt_write_enable_latch) else $error("halt without write latch");
    property p_irq_mask;
        !en_q |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked event raised irq");
    property p_ext_hidden;
        ext_read && !data_protect_fuse |=> ext_rdata == 8'h00;
    endproperty
    a_ext_hidden: assert property (p_ext_hidden) else $error("protected data leaked");
    property p_pm_read;
        pm_rd |-> ##[1:4] instr_ignore;
    endproperty
    a_pm_read: assert property (p_pm_read) else $error("program read took no slot");
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");
endmodule : nvw_ctrl_monitor

bind nvw_ctrl nvw_ctrl_monitor #(.ERASE_CNT(ERASE_CNT)) mon_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .instr_slot(instr_slot), .instr_ignore(instr_ignore),
    .cpu_halt(cpu_halt), .irq(irq), .data_protect_fuse(data_protect_fuse),
    .ext_read(ext_read), .ext_addr(ext_addr), .ext_rdata(ext_rdata));

// File: test/tb.sv
// Self-checking bench for the nonvolatile write controller
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nvw_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic instr_slot = 1'b0;
    logic fuse = 1'b1;
    logic ext_read = 1'b0;
    logic [7:0] ext_addr = 8'h03;
    logic [7:0] reg_rdata, ext_rdata;
    logic instr_ignore, cpu_halt, irq;
    int n_mismatch = 0;
    int comparisons = 0;
    nvw_ctrl #(.PWRUP_CNT(100), .ERASE_CNT(20), .EE_WRITE_CNT(20)) dut_u (.ref_clk(ref_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .instr_slot(instr_slot),
        .instr_ignore(instr_ignore), .cpu_halt(cpu_halt), .irq(irq), .data_protect_fuse(fuse),
        .ext_read(ext_read), .ext_addr(ext_addr), .ext_rdata(ext_rdata));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Core issues a slot every cycle unless halted
    always @(posedge ref_clk) instr_slot <= rst_n && !cpu_halt;
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_write <= 1'b1;
        reg_read <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
    endtask : wr
    task automatic cyc(input int n);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        reg_read <= 1'b1;
        reg_write <= 1'b0;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, e)
        @(posedge ref_clk);
    endtask : rd
    // Unlock must sit back to back with the start write
    // no other register write interleaved
    task automatic start(input logic [7:0] c);
        wr(OFS_UNLOCK, UNLOCK_FIRST);
        wr(OFS_UNLOCK, UNLOCK_SECOND);
        wr(OFS_CONTROL, c);
        cyc(1);
    endtask : start
    task automatic probe(input logic [7:0] e);
        ext_read <= 1'b1;
        @(posedge ref_clk);
        ext_read <= 1'b0;
        #1 `CHK(ext_rdata, e)
        @(posedge ref_clk);
    endtask : probe
    task automatic see_irq(input logic e);
        @(negedge ref_clk) `CHK(irq, e)
        @(posedge ref_clk);
    endtask : see_irq
    task automatic wait_halt(input logic v);
        for (int n = 0; n < 100 && cpu_halt !== v; n++) @(negedge ref_clk);
        `CHK(cpu_halt, v)
        @(posedge ref_clk);
    endtask : wait_halt
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
        wr(OFS_ADDR_LO, 8'h03);
        wr(OFS_DATA_LO, 8'h5A);
        wr(OFS_CONTROL, 8'h04);
        start(8'h06);
        cyc(25);
        rd(OFS_CONTROL, 8'h04);
        rd(OFS_IRQ_FLAGS, 8'h00);
        cyc(40);
        wr(OFS_IRQ_EN, 8'h10);
        start(8'h06);
        rd(OFS_CONTROL, 8'h06);
        cyc(25);
        rd(OFS_CONTROL, 8'h04);
        rd(OFS_IRQ_FLAGS, 8'h10);
        see_irq(1'b1);
        wr(OFS_IRQ_CLEAR, 8'h10);
        cyc(3);
        rd(OFS_IRQ_FLAGS, 8'h00);
        see_irq(1'b0);
        wr(OFS_IRQ_EN, 8'h00);
        start(8'h06);
        cyc(25);
        rd(OFS_IRQ_FLAGS, 8'h10);
        see_irq(1'b0);
        wr(OFS_IRQ_CLEAR, 8'h10);
        // Wrong value, then an intervening write, each breaks the unlock
        for (int k = 0; k < 2; k++) begin
            wr(OFS_UNLOCK, UNLOCK_FIRST);
            wr(k ? OFS_ADDR_LO : OFS_UNLOCK, k ? 8'h03 : 8'h11);
            wr(OFS_UNLOCK, UNLOCK_SECOND);
            wr(OFS_CONTROL, 8'h06);
            cyc(25);
            rd(OFS_IRQ_FLAGS, 8'h00);
        end
        wr(OFS_CONTROL, 8'h00);
        start(8'h06);
        cyc(25);
        rd(OFS_IRQ_FLAGS, 8'h00);
        fuse <= 1'b0;
        wr(OFS_DATA_LO, 8'h00);
        wr(OFS_CONTROL, 8'h05);
        cyc(2);
        rd(OFS_DATA_LO, 8'h5A);
        probe(8'h00);
        fuse <= 1'b1;
        probe(8'h5A);
        wr(OFS_CONTROL, 8'h84);
        // Unarmed program start must not skip slots
        wr(OFS_CONTROL, 8'h86);
        cyc(4);
        rd(OFS_STATUS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_ADDR_LO, 8'h08 + 8'(i));
            wr(OFS_DATA_LO, 8'h10 + 8'(i));
            wr(OFS_DATA_HI, 8'h2A);
            start(8'h86);
            if (i < 7) cyc(4);
        end
        wait_halt(1'b1);
        wait_halt(1'b0);
        wr(OFS_ADDR_LO, 8'h00);
        wr(OFS_CONTROL, 8'h85);
        cyc(6);
        rd(OFS_DATA_LO, 8'hFF);
        rd(OFS_DATA_HI, 8'h3F);
        wr(OFS_ADDR_LO, 8'h0B);
        wr(OFS_CONTROL, 8'h85);
        cyc(6);
        rd(OFS_DATA_LO, 8'h13);
        rd(OFS_DATA_HI, 8'h2A);
        print_verdict();
    end
endmodule : tb
